// ---- logic/oau_pkg.sv ----
package oau_pkg;
    // Register set geometry
    localparam int VIS_REGS = 32;
    localparam int BANKED_REGS = 12;
    localparam int PHYS_REGS = VIS_REGS + BANKED_REGS;
    localparam logic [5:0] ALT_BANK_BASE = 6'h20;
    localparam logic [4:0] ACC_REG = 5'h00;
    localparam logic [4:0] IX_BASE_REG = 5'h14;
    localparam logic [4:0] IX_LAST_REG = 5'h1b;
    localparam logic [1:0] RELZ_IX = 2'h3;
    localparam logic [15:0] IX_RESET = 16'h0000;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] WORD_STEP = 16'h0001;
    localparam logic [15:0] TWO_WORD_STEP = 16'h0002;

    // Opcode classes in bits 15:12
    localparam int F_OPC_LSB = 12;
    localparam int F_DST_LSB = 0;
    localparam int F_SRC_LSB = 5;
    localparam int F_IXS_LSB = 5;
    localparam int F_IXM_LSB = 7;
    localparam int F_LREG_LSB = 8;
    localparam int F_IMMIX_LSB = 8;
    localparam int F_JIX_LSB = 0;
    localparam int F_IMM_LSB = 0;
    localparam logic [3:0] OP_MV_RR = 4'h0;
    localparam logic [3:0] OP_MV_R_IX = 4'h1;
    localparam logic [3:0] OP_MV_IX_R = 4'h2;
    localparam logic [3:0] OP_MV_R_RA = 4'h3;
    localparam logic [3:0] OP_MV_RA_R = 4'h4;
    localparam logic [3:0] OP_MV_R_RZ = 4'h5;
    localparam logic [3:0] OP_MV_RZ_R = 4'h6;
    localparam logic [3:0] OP_MV_IMM_R = 4'h7;
    localparam logic [3:0] OP_MV_IMM_IX = 4'h8;
    localparam logic [3:0] OP_LONG_JUMP_ABS = 4'h9;
    localparam logic [3:0] OP_LONG_JUMP_IX = 4'ha;

    // Index modification modes
    localparam logic [1:0] IXM_PLAIN = 2'h0;
    localparam logic [1:0] IXM_POSTDEC = 2'h1;
    localparam logic [1:0] IXM_POSTINC = 2'h2;
    localparam logic [1:0] IXM_PREINC = 2'h3;

    typedef enum logic [8:0] {
        S_FETCH = 9'h001,
        S_ISSUE = 9'h002,
        S_DECODE = 9'h004,
        S_ISSUE2 = 9'h008,
        S_ABS = 9'h010,
        S_EXEC = 9'h020,
        S_ADDR = 9'h040,
        S_DATA = 9'h080,
        S_CAPT = 9'h100
    } state_e;

    // Visible register to physical slot, low twelve follow the bank select
    function automatic logic [5:0] phys_of(input logic [4:0] r, input logic alt);
        phys_of = (alt && (r < 5'(BANKED_REGS))) ? ALT_BANK_BASE + {1'b0, r} : {1'b0, r};
    endfunction
endpackage

// ---- logic/rf_if.sv ----
`timescale 1ns/1ns
interface rf_if;
    logic bank_alt;
    logic [4:0] rd_addr;
    logic [7:0] rd_data;
    logic wr_en;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
    logic ix_wr_en;
    logic [1:0] ix_wr_sel;
    logic [15:0] ix_wr_val;
    logic [3:0][15:0] ix_val;
    logic [7:0] acc;
    modport core (output bank_alt, rd_addr, wr_en, wr_addr, wr_data, ix_wr_en, ix_wr_sel,
        ix_wr_val, input rd_data, ix_val, acc);
    modport regs (input bank_alt, rd_addr, wr_en, wr_addr, wr_data, ix_wr_en, ix_wr_sel,
        ix_wr_val, output rd_data, ix_val, acc);
endinterface

// ---- logic/addr_calc.sv ----
`timescale 1ns/1ns
module addr_calc
    import oau_pkg::*;
(
    input wire logic [15:0] base,
    input wire logic [1:0] mode,
    input wire logic [7:0] offset,
    output logic [15:0] addr,
    output logic [15:0] next_ix,
    output logic upd
);
    // Sums wrap silently at the 16-bit boundary
    wire [15:0] inc = base + WORD_STEP;
    wire [15:0] dec = base - WORD_STEP;
    wire [15:0] rel = base + {8'h00, offset};

    // Pre-increment uses the bumped value, others the base plus offset
    assign addr = (mode == IXM_PREINC) ? inc : rel;
    assign next_ix = (mode == IXM_POSTDEC) ? dec : inc;
    assign upd = (mode != IXM_PLAIN);
endmodule

// ---- logic/reg_bank.sv ----
`timescale 1ns/1ns
module reg_bank
    import oau_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    rf_if.regs rf
);
    logic [7:0] mem_q [0:PHYS_REGS-1];
    logic [15:0] idx_q [0:3];

    // Visible R20..R27 are the four index pairs, low byte first
    wire rd_is_ix = (rf.rd_addr >= IX_BASE_REG) && (rf.rd_addr <= IX_LAST_REG);
    wire wr_is_ix = (rf.wr_addr >= IX_BASE_REG) && (rf.wr_addr <= IX_LAST_REG);
    wire [4:0] rd_off = rf.rd_addr - IX_BASE_REG;
    wire [4:0] wr_off = rf.wr_addr - IX_BASE_REG;
    wire [15:0] rd_pair = idx_q[rd_off[2:1]];
    wire [5:0] rd_phys = phys_of(rf.rd_addr, rf.bank_alt);
    wire [5:0] wr_phys = phys_of(rf.wr_addr, rf.bank_alt);

    assign rf.rd_data = rd_is_ix ? (rd_off[0] ? rd_pair[15:8] : rd_pair[7:0]) : mem_q[rd_phys];
    assign rf.acc = mem_q[phys_of(ACC_REG, rf.bank_alt)];

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ix
            assign rf.ix_val[gi] = idx_q[gi];
        end
    endgenerate

    // General storage carries no reset, software initialises it
    always_ff @(posedge clk) begin
        if (rf.wr_en && !wr_is_ix) begin
            mem_q[wr_phys] <= rf.wr_data;
        end
    end

    // Index pairs cleared by reset; address update wins over a byte write
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < 4; i++) begin
                idx_q[i] <= IX_RESET;
            end
        end else if (rf.ix_wr_en) begin
            idx_q[rf.ix_wr_sel] <= rf.ix_wr_val;
        end else if (rf.wr_en && wr_is_ix) begin
            if (wr_off[0]) begin
                idx_q[wr_off[2:1]][15:8] <= rf.wr_data;
            end else begin
                idx_q[wr_off[2:1]][7:0] <= rf.wr_data;
            end
        end
    end
endmodule

// ---- logic/operand_addressing_unit.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - Program address and instruction buses are 16 bits, addressing 16-bit words.
// - Most instructions take one word; some fetch a second immediate word first.
// - Data address is 16-bit byte address; low byte multiplexed on data lines.
// - Data bus is one byte; operands are bytes.
// - Only flow instructions treat 16-bit addresses as program word addresses.
// - Full register field picks R0-R31 of 44; R0-R11 follow bank select.
// - Limited register field reaches R0-R15 only, 28 physical with banks.
// - Immediate is an 8-bit field in the opcode word.
// - Absolute operand is the 16-bit second word, a program address.
// - Indirect addressing uses four 16-bit index registers built from register pairs.
// - Index modes: unchanged, post-decrement, post-increment, pre-increment.
// - Reset clears every index register to zero.
// - Long jump may take its target word address from an index register.
// - Immediate-relative address is relative base index plus unsigned 8-bit immediate.
// - Register-relative address is chosen index plus unsigned active accumulator.
// - Relative modes exist only for moves; other opcodes are rejected.
// - A move transfers exactly one byte per execution.
// - Move can write an immediate byte to memory at an unmodified index.
// - Immediate-relative and immediate-load moves use the limited register field.
// - Other instructions use only register, immediate, indexed and absolute operand modes.
module operand_addressing_unit
    import oau_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic bank_alt,
    output logic [15:0] pm_addr,
    output logic pm_rd,
    input wire logic [15:0] pm_data,
    output logic [7:0] dm_addr_hi,
    output logic [7:0] dm_ad_o,
    output logic dm_ad_oe,
    input wire logic [7:0] dm_ad_i,
    output logic dm_ale,
    output logic dm_rd,
    output logic dm_wr,
    output logic op_reject
);
    rf_if rf();

    state_e st_q, st_d;
    logic [15:0] pc_q, pc_d;
    logic [15:0] op_word_q;
    logic [15:0] abs_q;
    logic [4:0] dst_q;
    logic [7:0] wdata_q;
    logic [15:0] maddr_q;
    logic is_load_q;
    logic [15:0] pm_addr_q;
    logic pm_rd_q;
    logic [7:0] dm_addr_hi_q, dm_ad_o_q;
    logic dm_ad_oe_q, dm_ale_q, dm_rd_q, dm_wr_q, op_reject_q;

    // Field extraction from the latched opcode word
    wire [3:0] opc = op_word_q[F_OPC_LSB +: 4];
    wire [4:0] f_dst = op_word_q[F_DST_LSB +: 5];
    wire [4:0] f_src = op_word_q[F_SRC_LSB +: 5];
    wire [1:0] f_ixs = op_word_q[F_IXS_LSB +: 2];
    wire [1:0] f_ixm = op_word_q[F_IXM_LSB +: 2];
    wire [4:0] f_lreg = {1'b0, op_word_q[F_LREG_LSB +: 4]};
    wire [1:0] f_immix = op_word_q[F_IMMIX_LSB +: 2];
    wire [1:0] f_jix = op_word_q[F_JIX_LSB +: 2];
    wire [7:0] f_imm = op_word_q[F_IMM_LSB +: 8];

    // Opcode class decode
    wire op_rr = (opc == OP_MV_RR);
    wire op_r_ix = (opc == OP_MV_R_IX);
    wire op_ix_r = (opc == OP_MV_IX_R);
    wire op_r_ra = (opc == OP_MV_R_RA);
    wire op_ra_r = (opc == OP_MV_RA_R);
    wire op_r_rz = (opc == OP_MV_R_RZ);
    wire op_rz_r = (opc == OP_MV_RZ_R);
    wire op_imm_r = (opc == OP_MV_IMM_R);
    wire op_imm_ix = (opc == OP_MV_IMM_IX);
    wire op_jabs = (opc == OP_LONG_JUMP_ABS);
    wire op_jix = (opc == OP_LONG_JUMP_IX);
    wire op_ix = op_r_ix || op_ix_r;
    wire op_ra = op_r_ra || op_ra_r;
    wire op_rz = op_r_rz || op_rz_r;
    wire op_store = op_r_ix || op_r_ra || op_r_rz || op_imm_ix;
    wire op_load = op_ix_r || op_ra_r || op_rz_r;
    wire op_mem = op_store || op_load;
    // Relative modes are only reachable through move classes
    wire op_known = op_rr || op_mem || op_imm_r || op_jabs || op_jix;
    wire two_word = (pm_data[F_OPC_LSB +: 4] == OP_LONG_JUMP_ABS);

    // Index select and mode; relative forms never modify the index
    // Jump through index takes its pair from the low field, not the move field
    wire [1:0] ix_sel = op_rz ? RELZ_IX : (op_imm_ix ? f_immix : (op_jix ? f_jix : f_ixs));
    wire [1:0] ix_mode = op_ix ? f_ixm : IXM_PLAIN;
    wire [7:0] ix_off = op_ra ? rf.acc : (op_rz ? f_imm : 8'h00);
    wire [15:0] ix_base = rf.ix_val[ix_sel];
    wire [15:0] ea;
    wire [15:0] ix_next;
    wire ix_upd;

    addr_calc u_addr (
        .base(ix_base),
        .mode(ix_mode),
        .offset(ix_off),
        .addr(ea),
        .next_ix(ix_next),
        .upd(ix_upd)
    );

    reg_bank u_regs (
        .clk(clk),
        .srst(srst),
        .rf(rf)
    );

    // Register file port steering; full or limited field by opcode
    wire in_exec = (st_q == S_EXEC);
    wire in_capt = (st_q == S_CAPT);
    wire exec_wr = in_exec && (op_rr || op_imm_r);
    wire [4:0] exec_dst = op_rr ? f_dst : f_lreg;
    wire [4:0] load_dst = op_rz_r ? f_lreg : f_dst;
    assign rf.bank_alt = bank_alt;
    assign rf.rd_addr = op_rr ? f_src : (op_r_rz ? f_lreg : f_dst);
    assign rf.wr_en = exec_wr || in_capt;
    assign rf.wr_addr = in_capt ? dst_q : exec_dst;
    assign rf.wr_data = in_capt ? dm_ad_i : (op_rr ? rf.rd_data : f_imm);
    assign rf.ix_wr_en = in_exec && op_ix && ix_upd;
    assign rf.ix_wr_sel = ix_sel;
    assign rf.ix_wr_val = ix_next;

    // Jump target is a program word address, never a data address
    wire [15:0] jmp_tgt = op_jix ? ix_base : abs_q;
    wire [7:0] store_byte = op_imm_ix ? f_imm : rf.rd_data;

    // Sequencer next state; one-word ops skip the second fetch
    always_comb begin
        st_d = st_q;
        pc_d = pc_q;
        unique case (st_q)
            S_FETCH: begin
                st_d = S_ISSUE;
            end
            S_ISSUE: begin
                st_d = S_DECODE;
            end
            S_DECODE: begin
                st_d = two_word ? S_ISSUE2 : S_EXEC;
                pc_d = pc_q + (two_word ? TWO_WORD_STEP : WORD_STEP);
            end
            S_ISSUE2: begin
                st_d = S_ABS;
            end
            S_ABS: begin
                st_d = S_EXEC;
            end
            S_EXEC: begin
                st_d = op_mem ? S_ADDR : S_FETCH;
                if (op_jabs || op_jix) begin
                    pc_d = jmp_tgt;
                end
            end
            S_ADDR: begin
                st_d = S_DATA;
            end
            S_DATA: begin
                st_d = is_load_q ? S_CAPT : S_FETCH;
            end
            S_CAPT: begin
                st_d = S_FETCH;
            end
        endcase
    end

    // State, program counter and instruction latches
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= S_FETCH;
            pc_q <= PC_RESET;
            op_word_q <= 16'h0000;
            abs_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            pc_q <= pc_d;
            if (st_q == S_DECODE) begin
                op_word_q <= pm_data;
            end
            if (st_q == S_ABS) begin
                abs_q <= pm_data;
            end
        end
    end

    // Program memory strobe; word address goes out one cycle before data returns
    always_ff @(posedge clk) begin
        if (srst) begin
            pm_addr_q <= PC_RESET;
            pm_rd_q <= 1'b0;
        end else begin
            pm_rd_q <= (st_q == S_FETCH) || (st_q == S_DECODE && two_word);
            if (st_q == S_FETCH) begin
                pm_addr_q <= pc_q;
            end else if (st_q == S_DECODE && two_word) begin
                pm_addr_q <= pc_q + WORD_STEP;
            end
        end
    end

    // Operand latches for the data memory access
    always_ff @(posedge clk) begin
        if (srst) begin
            dst_q <= 5'h00;
            wdata_q <= 8'h00;
            maddr_q <= 16'h0000;
            is_load_q <= 1'b0;
        end else if (in_exec && op_mem) begin
            dst_q <= load_dst;
            wdata_q <= store_byte;
            maddr_q <= ea;
            is_load_q <= op_load;
        end
    end

    // Data bus: address phase multiplexes the low byte, then one byte strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            dm_addr_hi_q <= 8'h00;
            dm_ad_o_q <= 8'h00;
            dm_ad_oe_q <= 1'b0;
            dm_ale_q <= 1'b0;
            dm_rd_q <= 1'b0;
            dm_wr_q <= 1'b0;
        end else begin
            dm_ale_q <= in_exec && op_mem;
            dm_rd_q <= (st_q == S_ADDR) && is_load_q;
            dm_wr_q <= (st_q == S_ADDR) && !is_load_q;
            dm_ad_oe_q <= (in_exec && op_mem) || (st_q == S_ADDR && !is_load_q);
            if (in_exec && op_mem) begin
                dm_addr_hi_q <= ea[15:8];
                dm_ad_o_q <= ea[7:0];
            end else if (st_q == S_ADDR) begin
                dm_ad_o_q <= wdata_q;
            end
        end
    end

    // Unknown classes are flagged and skipped; one-cycle pulse
    always_ff @(posedge clk) begin
        if (srst) begin
            op_reject_q <= 1'b0;
        end else begin
            op_reject_q <= in_exec && !op_known;
        end
    end

    assign pm_addr = pm_addr_q;
    assign pm_rd = pm_rd_q;
    assign dm_addr_hi = dm_addr_hi_q;
    assign dm_ad_o = dm_ad_o_q;
    assign dm_ad_oe = dm_ad_oe_q;
    assign dm_ale = dm_ale_q;
    assign dm_rd = dm_rd_q;
    assign dm_wr = dm_wr_q;
    assign op_reject = op_reject_q;

    // Checks on the addressing behaviour
    a_ix_reset: assert property (@(posedge clk) srst |=> rf.ix_val == '0)
        else $error("index registers not cleared by reset");

    a_second_word: assert property (@(posedge clk) disable iff (srst)
        (st_q == S_DECODE && two_word) |=> pm_rd && pm_addr == $past(pm_addr) + WORD_STEP)
        else $error("second program word not fetched at next word address");

    a_mux_phase: assert property (@(posedge clk) disable iff (srst)
        dm_ale |-> dm_ad_oe ##1 (!dm_ale && (dm_rd ^ dm_wr) && $stable(dm_addr_hi)))
        else $error("address phase not followed by a single strobe");

    a_one_byte: assert property (@(posedge clk) disable iff (srst)
        (dm_rd || dm_wr) |=> !dm_rd && !dm_wr && !dm_ale)
        else $error("more than one byte moved");

    a_relz_sum: assert property (@(posedge clk) disable iff (srst)
        (in_exec && op_rz) |=> {dm_addr_hi, dm_ad_o} == $past(rf.ix_val[RELZ_IX] + {8'h00, f_imm}))
        else $error("immediate-relative address wrong");

    a_rela_sum: assert property (@(posedge clk) disable iff (srst)
        (in_exec && op_ra) |=> {dm_addr_hi, dm_ad_o} == $past(ix_base + {8'h00, rf.acc}))
        else $error("register-relative address wrong");

    a_post_inc: assert property (@(posedge clk) disable iff (srst)
        (in_exec && op_ix && f_ixm == IXM_POSTINC) |=>
        {dm_addr_hi, dm_ad_o} == $past(ix_base) &&
        rf.ix_val[$past(ix_sel)] == $past(ix_base) + 16'h0001)
        else $error("post-increment address or update wrong");

    a_post_dec: assert property (@(posedge clk) disable iff (srst)
        (in_exec && op_ix && f_ixm == IXM_POSTDEC) |=>
        {dm_addr_hi, dm_ad_o} == $past(ix_base) &&
        rf.ix_val[$past(ix_sel)] == $past(ix_base) - 16'h0001)
        else $error("post-decrement address or update wrong");

    a_plain_keep: assert property (@(posedge clk) disable iff (srst)
        (in_exec && (op_imm_ix || (op_ix && f_ixm == IXM_PLAIN))) |=> rf.ix_val == $past(rf.ix_val))
        else $error("unmodified index form changed an index");

    a_imm_store: assert property (@(posedge clk) disable iff (srst)
        (in_exec && op_imm_ix) |=> ##1 (dm_wr && dm_ad_o == $past(f_imm, 2)))
        else $error("immediate byte not written to memory");

    a_pre_inc: assert property (@(posedge clk) disable iff (srst)
        (in_exec && op_ix && f_ixm == IXM_PREINC) |=>
        {dm_addr_hi, dm_ad_o} == $past(ix_base) + 16'h0001)
        else $error("pre-increment address wrong");

    a_jump_ix: assert property (@(posedge clk) disable iff (srst)
        (in_exec && op_jix) |-> ##2 pm_rd && pm_addr == $past(ix_base, 2))
        else $error("long jump through index went elsewhere");

    a_reject_op: assert property (@(posedge clk) disable iff (srst)
        (in_exec && !op_known) |=> op_reject && !dm_ale)
        else $error("unknown opcode not rejected");

    a_jump_abs: assert property (@(posedge clk) disable iff (srst)
        (in_exec && op_jabs) |-> ##2 (pm_rd && pm_addr == $past(abs_q, 2)))
        else $error("long jump to absolute word went elsewhere");

    a_pm_pulse: assert property (@(posedge clk) disable iff (srst)
        pm_rd |=> !pm_rd)
        else $error("program read strobe longer than one cycle");

    a_two_word_pc: assert property (@(posedge clk) disable iff (srst)
        (st_q == S_DECODE && two_word) |=> pc_q == $past(pc_q) + 16'h0002)
        else $error("two-word instruction did not skip its operand word");

    a_load_capt: assert property (@(posedge clk) disable iff (srst)
        in_capt |-> (!dm_ad_oe && !dm_ale && $past(dm_rd)))
        else $error("read byte captured outside the released bus cycle");

    a_lreg_imm: assert property (@(posedge clk) disable iff (srst)
        (in_exec && op_imm_r) |-> (rf.wr_en && rf.wr_addr < 5'h10))
        else $error("immediate load reached past the limited range");

    a_store_oe: assert property (@(posedge clk) disable iff (srst)
        dm_wr |-> (dm_ad_oe && !dm_ale))
        else $error("write strobe without data driven on the bus");

    c_load_rel: cover property (@(posedge clk) disable iff (srst) in_exec && op_rz_r);
    c_store_imm: cover property (@(posedge clk) disable iff (srst) in_exec && op_imm_ix);
    c_jump_abs: cover property (@(posedge clk) disable iff (srst) in_exec && op_jabs);
    c_reject: cover property (@(posedge clk) disable iff (srst) op_reject);
    c_post_dec: cover property (@(posedge clk) disable iff (srst)
        in_exec && op_ix && f_ixm == IXM_POSTDEC);
endmodule

// ---- verification/mem_model.sv ----
`timescale 1ns/1ns
module mem_model (
    input wire logic clk,
    input wire logic [15:0] pm_addr,
    input wire logic pm_rd,
    output logic [15:0] pm_data,
    input wire logic [7:0] dm_addr_hi,
    input wire logic [7:0] dm_ad_o,
    input wire logic dm_ad_oe,
    input wire logic dm_ale,
    input wire logic dm_rd,
    input wire logic dm_wr,
    output logic [7:0] dm_ad_i
);
    logic [15:0] pm [0:65535];
    logic [7:0] dm [0:65535];
    logic [15:0] lat_addr = 16'h0000;
    logic [7:0] drv_q = 8'h00;
    logic [23:0] wr_log [$];

    initial pm_data = 16'h0000;

    // Shared bus wire: block wins while enabled, else our own drive
    assign dm_ad_i = dm_ad_oe ? dm_ad_o : drv_q;

    // Word-wide program port, no wait states; idle lines toggle so stale data never passes
    always @(posedge clk) begin
        pm_data <= pm_rd ? pm[pm_addr] : ~pm_data;
        // Bus side is read from the shared wire so a missing drive enable shows up
        if (dm_ale) lat_addr <= {dm_addr_hi, dm_ad_i};
        drv_q <= dm_rd ? dm[lat_addr] : ~drv_q;
        if (dm_wr) begin
            dm[lat_addr] <= dm_ad_i;
            wr_log.push_back({lat_addr, dm_ad_i});
        end
    end
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/1ns
module tb;
    import oau_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic bank_alt = 1'b0;
    logic [15:0] pm_addr, pm_data;
    logic pm_rd, dm_ad_oe, dm_ale, dm_rd, dm_wr, op_reject;
    logic [7:0] dm_addr_hi, dm_ad_o, dm_ad_i;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    int n_rej = 0;
    int n1;
    logic [15:0] pc_b, loop_a;
    logic [15:0] ix [4];
    logic [7:0] rv [32];
    logic [23:0] exp_q [$];
    logic [7:0] dmv [int];

    initial begin
        forever #2 clk = ~clk;
    end

    operand_addressing_unit uut (.clk(clk), .srst(srst), .bank_alt(bank_alt),
        .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data), .dm_addr_hi(dm_addr_hi),
        .dm_ad_o(dm_ad_o), .dm_ad_oe(dm_ad_oe), .dm_ad_i(dm_ad_i), .dm_ale(dm_ale),
        .dm_rd(dm_rd), .dm_wr(dm_wr), .op_reject(op_reject));

    mem_model mem (.clk(clk), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data),
        .dm_addr_hi(dm_addr_hi), .dm_ad_o(dm_ad_o), .dm_ad_oe(dm_ad_oe), .dm_ale(dm_ale),
        .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_ad_i(dm_ad_i));

    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Reject pulses and a hang guard well above the program length
    always @(posedge clk) begin
        cyc++;
        if (op_reject === 1'b1) n_rej++;
        if (cyc == 8000) begin
            n_fail++;
            wrap_up;
        end
    end

    task chk_val(input string what, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    task chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    // Program builder: each helper also advances the expected machine state
    task emit(input logic [15:0] w);
        mem.pm[pc_b] = w;
        pc_b++;
    endtask

    function automatic logic [7:0] rdm(input logic [15:0] a);
        if (!dmv.exists(int'(a))) begin
            dmv[int'(a)] = 8'($urandom);
            mem.dm[a] = dmv[int'(a)];
        end
        return dmv[int'(a)];
    endfunction

    task li(input logic [3:0] r, input logic [7:0] v);
        emit({OP_MV_IMM_R, r, v});
        rv[r] = v;
    endtask

    task mv(input logic [4:0] s, input logic [4:0] d);
        emit({OP_MV_RR, 2'h0, s, d});
        rv[d] = rv[s];
        if (d >= IX_BASE_REG && d <= IX_LAST_REG) begin
            if (d[0]) ix[(d - IX_BASE_REG) >> 1][15:8] = rv[s];
            else ix[(d - IX_BASE_REG) >> 1][7:0] = rv[s];
        end
    endtask

    task setix(input logic [1:0] n, input logic [15:0] v);
        li(4'h1, v[7:0]);
        mv(5'h1, IX_BASE_REG + {2'h0, n, 1'b0});
        li(4'h1, v[15:8]);
        mv(5'h1, IX_BASE_REG + {2'h0, n, 1'b1});
    endtask

    // One memory move; stores queue their expected bus record, loads fix the register
    task xfer(input logic [3:0] op, input logic [1:0] n, input logic [1:0] m,
            input logic [4:0] r, input logic [7:0] k);
        logic [15:0] a;
        a = ix[n];
        if (op == OP_MV_R_IX || op == OP_MV_IX_R) begin
            a = ix[n] + {15'h0, m == IXM_PREINC};
            if (m == IXM_POSTDEC) ix[n] = ix[n] - WORD_STEP;
            else if (m != IXM_PLAIN) ix[n] = ix[n] + WORD_STEP;
            emit({op, 3'h0, m, n, r});
        end else if (op == OP_MV_R_RA || op == OP_MV_RA_R) begin
            a = ix[n] + {8'h0, rv[0]};
            emit({op, 5'h0, n, r});
        end else begin
            a = ix[RELZ_IX] + {8'h0, k};
            emit({op, r[3:0], k});
        end
        // Later loads from a stored address must see the stored byte
        if (op == OP_MV_R_IX || op == OP_MV_R_RA || op == OP_MV_R_RZ) begin
            exp_q.push_back({a, rv[r]});
            dmv[int'(a)] = rv[r];
        end else begin
            rv[r] = rdm(a);
        end
    endtask

    task jmp_abs(input logic [15:0] t);
        emit({OP_LONG_JUMP_ABS, 12'h000});
        emit(t);
        pc_b = t;
    endtask

    initial begin
        void'($urandom(52519));
        pc_b = PC_RESET;
        for (int i = 0; i < 4; i++) ix[i] = IX_RESET;
        // Immediate to memory at each untouched index
        for (int k = 0; k < 4; k++) begin
            exp_q.push_back({IX_RESET, 8'(k + 8'h5a)});
            dmv[int'(IX_RESET)] = 8'(k + 8'h5a);
            emit({OP_MV_IMM_IX, 2'h0, 2'(k), 8'(k + 8'h5a)});
        end
        setix(2'h0, 16'($urandom));
        setix(2'h1, 16'hffff);
        setix(2'h2, {2'h1, 14'($urandom)});
        setix(2'h3, 16'($urandom));
        li(4'h2, 8'($urandom));
        li(4'hc, 8'($urandom));
        // All four index modes, starting at the top of the space to force wrap
        for (int m = 0; m < 4; m++) begin
            xfer(OP_MV_R_IX, 2'h1, 2'(m), 5'h2, 8'h0);
        end
        for (int m = 0; m < 4; m++) begin
            xfer(OP_MV_IX_R, 2'h2, 2'(m), 5'(4 + m), 8'h0);
            mv(5'(4 + m), 5'(16 + m));
            xfer(OP_MV_R_IX, 2'h0, IXM_PLAIN, 5'(16 + m), 8'h0);
        end
        li(4'h0, 8'($urandom));
        xfer(OP_MV_R_RA, 2'h1, IXM_PLAIN, 5'h2, 8'h0);
        xfer(OP_MV_RA_R, 2'h2, IXM_PLAIN, 5'h9, 8'h0);
        xfer(OP_MV_R_IX, 2'h0, IXM_PLAIN, 5'h9, 8'h0);
        xfer(OP_MV_R_RZ, 2'h0, IXM_PLAIN, 5'h5, 8'hff);
        xfer(OP_MV_RZ_R, 2'h0, IXM_PLAIN, 5'hf, 8'($urandom));
        xfer(OP_MV_R_IX, 2'h0, IXM_PLAIN, 5'hf, 8'h0);
        // Unhandled classes are skipped with a pulse each
        for (int c = 11; c < 16; c++) emit({4'(c), 12'h000});
        emit({OP_LONG_JUMP_IX, 10'h000, 2'h2});
        pc_b = ix[2];
        xfer(OP_MV_R_IX, 2'h0, IXM_PLAIN, 5'h2, 8'h0);
        jmp_abs({8'h20, 8'($urandom)});
        loop_a = pc_b;
        jmp_abs(loop_a);
        n1 = exp_q.size();
        // Second phase runs on the alternate bank
        pc_b = 16'h0800;
        li(4'h0, 8'($urandom));
        xfer(OP_MV_R_RA, 2'h3, IXM_PLAIN, 5'hc, 8'h0);
        jmp_abs(pc_b);
        repeat (16) @(posedge clk);
        #1 srst = 1'b0;
        for (int i = 0; i < 4 && pm_rd !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk_byte("first fetch strobe", 8'h01, {7'h00, pm_rd});
        chk_val("first fetch address", PC_RESET, pm_addr);
        while (mem.wr_log.size() < n1) @(posedge clk);
        #1 bank_alt = 1'b1;
        mem.pm[loop_a + WORD_STEP] = 16'h0800;
        while (mem.wr_log.size() < exp_q.size()) @(posedge clk);
        repeat (30) @(posedge clk);
        chk_val("store count", 16'(exp_q.size()), 16'(mem.wr_log.size()));
        foreach (exp_q[i]) begin
            if (i < mem.wr_log.size()) begin
                chk_val("store address", exp_q[i][23:8], mem.wr_log[i][23:8]);
                chk_byte("store byte", exp_q[i][7:0], mem.wr_log[i][7:0]);
            end
        end
        chk_val("reject count", 16'h0005, 16'(n_rej));
        wrap_up;
    end
endmodule
